// [shared/sfcs_consts.vh]
// shared constants of the serial flash command sequencer
// assumes a 50 MHz system clock and a mode 0 serial flash link
`ifndef SFCS_CONSTS_VH
`define SFCS_CONSTS_VH

// flash command bytes
`define SFCS_CMD_WRSR      8'h01
`define SFCS_CMD_PROG      8'h02
`define SFCS_CMD_READ      8'h03
`define SFCS_CMD_WRDI      8'h04
`define SFCS_CMD_RDSR      8'h05
`define SFCS_CMD_WREN      8'h06
`define SFCS_CMD_ERASE     8'h20
`define SFCS_CMD_QREAD     8'h6B
`define SFCS_CMD_RDID      8'h9F

// operation codes on the command port
`define SFCS_OP_READ       4'h0
`define SFCS_OP_QREAD      4'h1
`define SFCS_OP_PROG       4'h2
`define SFCS_OP_ERASE      4'h3
`define SFCS_OP_RDID       4'h4
`define SFCS_OP_RDSR       4'h5
`define SFCS_OP_WRSR       4'h6
`define SFCS_OP_WREN       4'h7
`define SFCS_OP_WRDI       4'h8

// reported operation state
`define SFCS_ST_IDLE       2'h0
`define SFCS_ST_WORKING    2'h1
`define SFCS_ST_DONE       2'h2

// flash status busy bit, id length, address length
`define SFCS_WIP_BIT       0
`define SFCS_ID_BYTES      16'h0003
`define SFCS_ADDR_BYTES    2'h3
`define SFCS_ONE_BYTE      16'h0001
`define SFCS_BYTE_BITS     4'h8
`define SFCS_QUAD_CLKS     4'h2

// timing
`define SFCS_CLK_NS        20
`define SFCS_SCK_HALF_NS   80
`define SFCS_CS_GAP_NS     100
`define SFCS_HALF_CYC      ((`SFCS_SCK_HALF_NS + `SFCS_CLK_NS - 1) / `SFCS_CLK_NS)
`define SFCS_GAP_CYC       ((`SFCS_CS_GAP_NS + `SFCS_CLK_NS - 1) / `SFCS_CLK_NS)

`endif

// [hdl/sfcs_sync.v]
// two-flop synchroniser, one generate branch per bit
// assumes inputs come from pins outside the clk_sys domain
module sfcs_sync #(
	parameter WIDTH = 4
) (
	// clock and reset
	input  wire             clk_sys,
	input  wire             reset,
	// pin side and synchronised side
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg stage1;
			reg stage2;
			always @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					stage1 <= 1'b0;
					stage2 <= 1'b0;
				end else begin
					stage1 <= async_in[i];
					stage2 <= stage1;
				end
			end
			assign sync_out[i] = stage2;
		end
	endgenerate
endmodule // sfcs_sync

// [hdl/sfcs_buf.v]
// small ring buffer with valid/ready on both sides
// assumes both sides run on clk_sys; DEPTH is a power of two
module sfcs_buf #(
	parameter WIDTH = 8,
	parameter DEPTH = 2,
	parameter AW    = 1
) (
	// clock and reset
	input  wire             clk_sys,
	input  wire             reset,
	// filling side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// draining side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wp;
	reg [AW-1:0]    rp;
	reg [AW:0]      cnt;
	wire            push;
	wire            pop;

	assign in_ready  = (cnt != DEPTH[AW:0]);
	assign out_valid = (cnt != {(AW+1){1'b0}});
	assign out_data  = mem[rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always @(posedge clk_sys) begin
		if (push) begin
			mem[wp] <= in_data;
		end
	end

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wp  <= {AW{1'b0}};
			rp  <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wp <= wp + 1'b1;
			end
			if (pop) begin
				rp <= rp + 1'b1;
			end
			if (push && !pop) begin
				cnt <= cnt + 1'b1;
			end else if (pop && !push) begin
				cnt <= cnt - 1'b1;
			end
		end
	end
endmodule // sfcs_buf

// [hdl/sfcs_seq.v]
// serial flash command sequencer: runs one flash operation per command
// assumes a mode 0 serial NOR flash on the pins; the serial clock is made here
`include "sfcs_consts.vh"
module sfcs_seq (
	// clock and reset
	input  wire        clk_sys,
	input  wire        reset,
	// command port
	input  wire        cmd_valid,
	output wire        cmd_ready,
	input  wire [3:0]  cmd_op,
	input  wire [23:0] cmd_addr,
	input  wire [15:0] cmd_count,
	input  wire [7:0]  cmd_status,
	// program data stream
	input  wire        wr_valid,
	output wire        wr_ready,
	input  wire [7:0]  wr_data,
	// read data stream
	output wire        rd_valid,
	input  wire        rd_ready,
	output wire [7:0]  rd_data,
	// results
	output reg  [1:0]  op_in_progress_state,
	output reg         op_done,
	output reg  [7:0]  flash_status,
	output reg  [7:0]  id_manuf,
	output reg  [15:0] id_device,
	output reg         flash_absent,
	// flash pins
	output reg         flash_sclk,
	output reg         flash_cs_n,
	output wire [3:0]  dq_out,
	output wire [3:0]  dq_oe_n,
	input  wire [3:0]  dq_in
);
	localparam [3:0] S_IDLE  = 4'h0;
	localparam [3:0] S_WREN  = 4'h1;
	localparam [3:0] S_GAP   = 4'h2;
	localparam [3:0] S_CMD   = 4'h3;
	localparam [3:0] S_ADDR  = 4'h4;
	localparam [3:0] S_DUMMY = 4'h5;
	localparam [3:0] S_WDATA = 4'h6;
	localparam [3:0] S_RDATA = 4'h7;
	localparam [3:0] S_TAIL  = 4'h8;
	localparam [3:0] S_PCMD  = 4'h9;
	localparam [3:0] S_PRD   = 4'hA;
	localparam [3:0] S_END   = 4'hB;
	localparam integer HALF_I = `SFCS_HALF_CYC;
	localparam integer GAP_I  = `SFCS_GAP_CYC;
	localparam [2:0] HALF    = HALF_I[2:0];
	localparam [2:0] GAP     = GAP_I[2:0];

	reg  [3:0]  state;
	reg  [3:0]  op;
	reg  [23:0] addr;
	reg  [15:0] count;
	reg  [7:0]  wrsr_val;
	reg  [1:0]  addr_idx;
	reg  [2:0]  gap_cnt;
	reg         gap_poll;
	reg  [2:0]  div;
	reg  [3:0]  clk_left;
	reg  [7:0]  tx;
	reg  [7:0]  rx;
	reg         eng_run;
	reg         byte_end;
	reg         wide;
	reg         hiz;
	reg         push;
	wire [3:0]  dq_s;
	wire        buf_ready;
	wire        stream_rd;
	wire        rx_room;

	function [7:0] opcode;
		input [3:0] o;
		begin
			case (o)
				`SFCS_OP_READ:  opcode = `SFCS_CMD_READ;
				`SFCS_OP_QREAD: opcode = `SFCS_CMD_QREAD;
				`SFCS_OP_PROG:  opcode = `SFCS_CMD_PROG;
				`SFCS_OP_ERASE: opcode = `SFCS_CMD_ERASE;
				`SFCS_OP_RDID:  opcode = `SFCS_CMD_RDID;
				`SFCS_OP_RDSR:  opcode = `SFCS_CMD_RDSR;
				`SFCS_OP_WRSR:  opcode = `SFCS_CMD_WRSR;
				`SFCS_OP_WRDI:  opcode = `SFCS_CMD_WRDI;
				default:        opcode = `SFCS_CMD_WREN;
			endcase
		end
	endfunction

	sfcs_sync #(
		.WIDTH(4)
	) u_sync (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.async_in (dq_in),
		.sync_out (dq_s)
	);

	sfcs_buf #(
		.WIDTH(8),
		.DEPTH(2),
		.AW   (1)
	) u_buf (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.in_valid  (push),
		.in_ready  (buf_ready),
		.in_data   (rx),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);

	assign stream_rd = (op == `SFCS_OP_READ) || (op == `SFCS_OP_QREAD);
	// a READ/QREAD byte only starts with a free slot, so a stalled reader stops the clock
	assign rx_room   = !stream_rd || (buf_ready && !push);
	assign cmd_ready = (state == S_IDLE);
	assign wr_ready  = (state == S_WDATA) && !eng_run && (count != 16'h0000);
	// dq0 carries commands; dq2/dq3 held high as protect/hold until the quad read dummy byte
	assign dq_out    = {2'b11, 1'b0, tx[7]};
	assign dq_oe_n   = {hiz, hiz, 1'b1, hiz};

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state                <= S_IDLE;
			op                   <= `SFCS_OP_READ;
			addr                 <= 24'h000000;
			count                <= 16'h0000;
			wrsr_val             <= 8'h00;
			addr_idx             <= 2'h0;
			gap_cnt              <= 3'h0;
			gap_poll             <= 1'b0;
			div                  <= 3'h0;
			clk_left             <= 4'h0;
			tx                   <= 8'h00;
			rx                   <= 8'h00;
			eng_run              <= 1'b0;
			byte_end             <= 1'b0;
			wide                 <= 1'b0;
			hiz                  <= 1'b0;
			push                 <= 1'b0;
			op_in_progress_state <= `SFCS_ST_IDLE;
			op_done              <= 1'b0;
			flash_status         <= 8'h00;
			id_manuf             <= 8'h00;
			id_device            <= 16'h0000;
			flash_absent         <= 1'b0;
			flash_sclk           <= 1'b0;
			flash_cs_n           <= 1'b1;
		end else begin
			byte_end <= 1'b0;
			push     <= 1'b0;
			op_done  <= 1'b0;
			// byte engine: sample on rising edge, shift on falling edge
			if (eng_run) begin
				if (div == HALF - 3'h1) begin
					div <= 3'h0;
					if (!flash_sclk) begin
						flash_sclk <= 1'b1;
						if (wide) begin
							rx <= {rx[3:0], dq_s};
						end else begin
							rx <= {rx[6:0], dq_s[1]};
						end
					end else begin
						flash_sclk <= 1'b0;
						tx         <= {tx[6:0], 1'b0};
						clk_left   <= clk_left - 4'h1;
						if (clk_left == 4'h1) begin
							eng_run  <= 1'b0;
							byte_end <= 1'b1;
						end
					end
				end else begin
					div <= div + 3'h1;
				end
			end
			case (state)
				S_IDLE: begin
					if (cmd_valid) begin
						op                   <= cmd_op;
						addr                 <= cmd_addr;
						wrsr_val             <= cmd_status;
						op_in_progress_state <= `SFCS_ST_WORKING;
						flash_cs_n           <= 1'b0;
						eng_run              <= 1'b1;
						div                  <= 3'h0;
						clk_left             <= `SFCS_BYTE_BITS;
						if (cmd_op == `SFCS_OP_RDID) begin
							count <= `SFCS_ID_BYTES;
						end else if (cmd_op == `SFCS_OP_RDSR) begin
							count <= `SFCS_ONE_BYTE;
						end else begin
							count <= cmd_count;
						end
						// flash forgets write enable after each program/erase
						if (cmd_op == `SFCS_OP_PROG || cmd_op == `SFCS_OP_ERASE) begin
							tx    <= `SFCS_CMD_WREN;
							state <= S_WREN;
						end else begin
							tx    <= opcode(cmd_op);
							state <= S_CMD;
						end
					end
				end
				S_WREN: begin
					if (byte_end) begin
						flash_cs_n <= 1'b1;
						gap_cnt    <= 3'h0;
						gap_poll   <= 1'b0;
						state      <= S_GAP;
					end
				end
				S_GAP: begin
					// write enable and polls only take effect on chip select rising
					if (gap_cnt == GAP - 3'h1) begin
						flash_cs_n <= 1'b0;
						eng_run    <= 1'b1;
						div        <= 3'h0;
						clk_left   <= `SFCS_BYTE_BITS;
						if (gap_poll) begin
							tx    <= `SFCS_CMD_RDSR;
							state <= S_PCMD;
						end else begin
							tx    <= opcode(op);
							state <= S_CMD;
						end
					end else begin
						gap_cnt <= gap_cnt + 3'h1;
					end
				end
				S_CMD: begin
					if (byte_end) begin
						if (op == `SFCS_OP_READ || op == `SFCS_OP_QREAD ||
							op == `SFCS_OP_PROG || op == `SFCS_OP_ERASE) begin
							tx       <= addr[23:16];
							addr_idx <= 2'h1;
							eng_run  <= 1'b1;
							div      <= 3'h0;
							clk_left <= `SFCS_BYTE_BITS;
							state    <= S_ADDR;
						end else if (op == `SFCS_OP_WRSR) begin
							tx       <= wrsr_val;
							eng_run  <= 1'b1;
							div      <= 3'h0;
							clk_left <= `SFCS_BYTE_BITS;
							state    <= S_TAIL;
						end else if (op == `SFCS_OP_RDID || op == `SFCS_OP_RDSR) begin
							state <= S_RDATA;
						end else begin
							state <= S_END;
						end
					end
				end
				S_ADDR: begin
					if (byte_end) begin
						if (addr_idx != `SFCS_ADDR_BYTES) begin
							tx       <= (addr_idx == 2'h1) ? addr[15:8] : addr[7:0];
							addr_idx <= addr_idx + 2'h1;
							eng_run  <= 1'b1;
							div      <= 3'h0;
							clk_left <= `SFCS_BYTE_BITS;
						end else if (op == `SFCS_OP_ERASE) begin
							flash_cs_n <= 1'b1;
							gap_cnt    <= 3'h0;
							gap_poll   <= 1'b1;
							state      <= S_GAP;
						end else if (op == `SFCS_OP_PROG) begin
							state <= S_WDATA;
						end else if (op == `SFCS_OP_QREAD) begin
							// dummy byte: lines released so the flash may turn them round
							tx       <= 8'h00;
							hiz      <= 1'b1;
							eng_run  <= 1'b1;
							div      <= 3'h0;
							clk_left <= `SFCS_BYTE_BITS;
							state    <= S_DUMMY;
						end else begin
							state <= S_RDATA;
						end
					end
				end
				S_DUMMY: begin
					if (byte_end) begin
						wide  <= 1'b1;
						state <= S_RDATA;
					end
				end
				S_WDATA: begin
					if (!eng_run) begin
						if (count == 16'h0000) begin
							state <= S_END;
						end else if (wr_valid) begin
							tx       <= wr_data;
							count    <= count - 16'h0001;
							eng_run  <= 1'b1;
							div      <= 3'h0;
							clk_left <= `SFCS_BYTE_BITS;
						end
					end
				end
				S_RDATA: begin
					if (byte_end) begin
						if (stream_rd) begin
							push <= 1'b1;
						end else if (op == `SFCS_OP_RDSR) begin
							flash_status <= rx;
						end else begin
							id_manuf  <= id_device[15:8];
							id_device <= {id_device[7:0], rx};
						end
					end else if (!eng_run) begin
						if (count == 16'h0000) begin
							state <= S_END;
						end else if (rx_room) begin
							tx       <= 8'h00;
							count    <= count - 16'h0001;
							eng_run  <= 1'b1;
							div      <= 3'h0;
							clk_left <= wide ? `SFCS_QUAD_CLKS : `SFCS_BYTE_BITS;
						end
					end
				end
				S_TAIL: begin
					if (byte_end) begin
						state <= S_END;
					end
				end
				S_PCMD: begin
					if (byte_end) begin
						tx       <= 8'h00;
						eng_run  <= 1'b1;
						div      <= 3'h0;
						clk_left <= `SFCS_BYTE_BITS;
						state    <= S_PRD;
					end
				end
				S_PRD: begin
					if (byte_end) begin
						flash_status <= rx;
						if (rx[`SFCS_WIP_BIT]) begin
							flash_cs_n <= 1'b1;
							gap_cnt    <= 3'h0;
							state      <= S_GAP;
						end else begin
							state <= S_END;
						end
					end
				end
				S_END: begin
					flash_cs_n           <= 1'b1;
					wide                 <= 1'b0;
					hiz                  <= 1'b0;
					op_done              <= 1'b1;
					op_in_progress_state <= `SFCS_ST_DONE;
					if (op == `SFCS_OP_RDID) begin
						flash_absent <= ({id_manuf, id_device} == 24'h000000) ||
							({id_manuf, id_device} == 24'hFFFFFF);
					end
					state <= S_IDLE;
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end
endmodule // sfcs_seq

// [test/sfcs_checker.sv]
// port checker for the serial flash command sequencer
// assumes it is bound onto sfcs_seq; one clock domain, reset active high
module sfcs_checker (
	// clock and reset
	input logic       clk_sys,
	input logic       reset,
	// command port
	input logic       cmd_valid,
	input logic       cmd_ready,
	input logic [3:0] cmd_op,
	// results and pins
	input logic [1:0] op_in_progress_state,
	input logic       op_done,
	input logic       flash_sclk,
	input logic       flash_cs_n,
	input logic [3:0] dq_out,
	input logic [3:0] dq_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence s_take;
		cmd_valid && cmd_ready;
	endsequence
	sequence s_high4;
		flash_sclk [*4] ##1 !flash_sclk;
	endsequence
	a_take_busy: assert property (s_take |=> !cmd_ready && op_in_progress_state == 2'h1)
		else $error("take did not enter working state");
	a_busy_refuse: assert property (op_in_progress_state == 2'h1 |-> !cmd_ready)
		else $error("command accepted while working");
	a_done_end: assert property (op_done |-> flash_cs_n && op_in_progress_state == 2'h2)
		else $error("done without released select and done state");
	a_done_pulse: assert property (op_done |=> !op_done && cmd_ready)
		else $error("done not a single pulse followed by ready");
	a_first_bit: assert property (s_take |=> !flash_cs_n && dq_out[0] == $past(cmd_op == 4'h4))
		else $error("first command bit wrong");
	a_cs_start: assert property ($fell(flash_cs_n) |-> !flash_sclk)
		else $error("select fell with serial clock high");
	a_cs_idle: assert property (flash_cs_n |-> !flash_sclk)
		else $error("serial clock high while deselected");
	a_sclk_high: assert property ($rose(flash_sclk) |-> s_high4)
		else $error("serial clock high phase not four cycles");
	a_rx_free: assert property (dq_oe_n[1] && (!flash_cs_n || dq_oe_n == 4'h2))
		else $error("receive line driven or lines released while deselected");
endmodule // sfcs_checker

bind sfcs_seq sfcs_checker sfcs_checker_inst (.clk_sys(clk_sys), .reset(reset),
	.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
	.op_in_progress_state(op_in_progress_state), .op_done(op_done),
	.flash_sclk(flash_sclk), .flash_cs_n(flash_cs_n), .dq_out(dq_out), .dq_oe_n(dq_oe_n));

// [test/sfcs_flash_model.sv]
// behavioural serial NOR flash facing the sequencer
// assumes mode 0: input sampled on clock rise, output changed on clock fall
module sfcs_flash_model #(
	parameter [7:0]  MANUF_ID = 8'h00,
	parameter [15:0] DEV_ID   = 16'h0000
) (
	// serial pins and the absent/pull_up test controls
	input  wire       flash_sclk,
	input  wire       flash_cs_n,
	input  wire [3:0] pin,
	input  wire       absent,
	input  wire       pull_up,
	output wire [3:0] dq_drv
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  logq [$];
	logic [7:0]  pq [$];
	logic [31:0] sh = 32'h0;
	logic [7:0]  cmd = 8'h00;
	logic [7:0]  sreg = 8'h00;
	logic [7:0]  wbyte = 8'h00;
	logic [23:0] adr = 24'h000000;
	logic [11:0] sect = 12'h000;
	logic        wel = 1'b0;
	logic [3:0]  drv = 4'h0;
	int          bc = 0;
	int          polls = 0;
	// missing part: the pull resistor sets every line; deselected: lines flip, never hold data
	assign dq_drv = absent ? {4{pull_up}} : (flash_cs_n ? ~drv : drv);
	function automatic logic [3:0] resp(int n);
		logic [31:0] idv;
		logic [7:0]  st;
		logic [7:0]  b;
		idv = {8'h00, MANUF_ID, DEV_ID};
		st = {sreg[7:2], wel, polls != 0};
		b = adr[7:0] + 8'((n - 32) / 8);
		resp = 4'h0;
		if (cmd == 8'h9F && n < 32) resp[1] = idv[31 - n];
		if (cmd == 8'h05) resp[1] = st[7 - n % 8];
		if (cmd == 8'h03 && n >= 32) resp[1] = b[7 - n % 8];
		if (cmd == 8'h6B && n >= 40) begin
			b = adr[7:0] + 8'((n - 40) / 2);
			resp = (n % 2 == 0) ? b[7:4] : b[3:0];
		end
	endfunction
	always @(posedge flash_sclk) begin
		if (!flash_cs_n) begin
			sh = {sh[30:0], pin[0]};
			bc++;
			if (bc == 8) begin
				cmd = sh[7:0];
				logq.push_back(cmd);
			end
			if (bc == 32) adr = sh[23:0];
			if (bc == 16 && cmd == 8'h01) wbyte = sh[7:0];
			if (bc > 32 && bc % 8 == 0 && cmd == 8'h02 && wel) pq.push_back(sh[7:0]);
		end
	end
	always @(negedge flash_sclk or negedge flash_cs_n)
		if (!flash_cs_n) drv <= resp(bc);
	always @(posedge flash_cs_n) begin
		if (cmd == 8'h06 && bc == 8) wel = 1'b1;
		if (cmd == 8'h04) wel = 1'b0;
		if (cmd == 8'h01 && wel && bc >= 16) sreg = wbyte;
		// low twelve address bits are ignored: one whole sector goes
		if (cmd == 8'h20 && wel && bc == 32) begin
			sect = adr[23:12];
			polls = 2;
		end
		if (cmd == 8'h05 && polls > 0) polls--;
		if (cmd inside {8'h01, 8'h02, 8'h20}) wel = 1'b0;
		bc = 0;
		cmd = 8'h00;
	end
endmodule // sfcs_flash_model

// [test/sfcs_seq_tb.sv]
// self-checking bench: sequencer against the behavioural flash
// assumes sfcs_seq, sfcs_flash_model and the checker are compiled first
module sfcs_seq_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// arbitrary identity values, not of any real part
	localparam [7:0]  MANUF_ID = 8'h5A;
	localparam [15:0] DEV_ID   = 16'hC3E1;
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic        cmd_valid = 1'b0;
	logic [3:0]  cmd_op = 4'h0;
	logic [23:0] cmd_addr = 24'h000000;
	logic [15:0] cmd_count = 16'h0000;
	logic [7:0]  cmd_status = 8'h00;
	logic        wr_valid = 1'b1;
	logic        rd_ready = 1'b1;
	logic        absent = 1'b0;
	logic        pull_up = 1'b1;
	logic [7:0]  wr_idx = 8'h00;
	logic [7:0]  rdq [$];
	wire         cmd_ready, wr_ready, rd_valid, op_done, flash_absent, flash_sclk, flash_cs_n;
	wire [7:0]   rd_data, flash_status, id_manuf;
	wire [15:0]  id_device;
	wire [1:0]   op_in_progress_state;
	wire [3:0]   dq_out, dq_oe_n, dq_in, fl_drv;
	wire [7:0]   wr_data = 8'h50 + wr_idx;
	int          bad_count = 0;
	int          n_tests = 0;
	// each line carries whoever has it enabled
	assign dq_in = (~dq_oe_n & dq_out) | (dq_oe_n & fl_drv);
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
		if (wr_valid && wr_ready === 1'b1) wr_idx <= #1 wr_idx + 8'h01;
	always @(posedge clk_sys)
		if (rd_valid === 1'b1 && rd_ready) rdq.push_back(rd_data);
	sfcs_seq sfcs_seq_inst (.clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_count(cmd_count),
		.cmd_status(cmd_status), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
		.rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
		.op_in_progress_state(op_in_progress_state), .op_done(op_done),
		.flash_status(flash_status), .id_manuf(id_manuf), .id_device(id_device),
		.flash_absent(flash_absent), .flash_sclk(flash_sclk), .flash_cs_n(flash_cs_n),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
	sfcs_flash_model #(.MANUF_ID(MANUF_ID), .DEV_ID(DEV_ID)) sfcs_flash_model_inst (
		.flash_sclk(flash_sclk), .flash_cs_n(flash_cs_n), .pin(dq_in), .absent(absent),
		.pull_up(pull_up), .dq_drv(fl_drv));
	task automatic cmp(string what, logic [23:0] exp, logic [23:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic issue(logic [3:0] op, logic [23:0] adr, logic [15:0] cnt, logic [7:0] st);
		sfcs_flash_model_inst.logq.delete();
		cmd_op = op;
		cmd_addr = adr;
		cmd_count = cnt;
		cmd_status = st;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1) begin
			@(posedge clk_sys);
			#1;
		end
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b0;
		cmp("op state", 24'h1, {22'h0, op_in_progress_state});
	endtask
	task automatic finish_op();
		int n;
		n = 0;
		while (op_done !== 1'b1 && n < 5000) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		cmp("op_done", 24'h1, {23'h0, op_done});
		cmp("op state", 24'h2, {22'h0, op_in_progress_state});
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
	task automatic run(logic [3:0] op, logic [23:0] adr, logic [15:0] cnt, logic [7:0] st);
		issue(op, adr, cnt, st);
		finish_op();
	endtask
	task automatic chk_log(logic [7:0] e [$]);
		cmp("frames", 24'(e.size()), 24'(sfcs_flash_model_inst.logq.size()));
		foreach (e[i])
			cmp("command byte", {16'h0, e[i]}, {16'h0, sfcs_flash_model_inst.logq[i]});
	endtask
	task automatic chk_rd(logic [7:0] base, int n);
		cmp("byte count", 24'(n), 24'(rdq.size()));
		foreach (rdq[i]) cmp("read byte", 24'(base + i), {16'h0, rdq[i]});
	endtask
	task automatic t_ident();
		// present then missing, once with the line pulled low and once pulled high
		for (int k = 0; k < 2; k++) begin
			absent = 1'b0;
			run(4'h4, 24'h0, 16'h0, 8'h0);
			chk_log('{8'h9F});
			cmp("manufacturer", {16'h0, MANUF_ID}, {16'h0, id_manuf});
			cmp("device", {8'h0, DEV_ID}, {8'h0, id_device});
			cmp("absent", 24'h0, {23'h0, flash_absent});
			absent = 1'b1;
			pull_up = k[0];
			run(4'h4, 24'h0, 16'h0, 8'h0);
			cmp("pulled id", {24{pull_up}}, {id_manuf, id_device});
			cmp("absent", 24'h1, {23'h0, flash_absent});
		end
		absent = 1'b0;
		pull_up = 1'b1;
	endtask
	task automatic t_regs();
		run(4'h7, 24'h0, 16'h0, 8'h0);
		run(4'h8, 24'h0, 16'h0, 8'h0);
		chk_log('{8'h04});
		cmp("write latch", 24'h0, {23'h0, sfcs_flash_model_inst.wel});
		run(4'h7, 24'h0, 16'h0, 8'h0);
		chk_log('{8'h06});
		run(4'h6, 24'h0, 16'h0, 8'h1C);
		chk_log('{8'h01});
		run(4'h5, 24'h0, 16'h0, 8'h0);
		chk_log('{8'h05});
		cmp("status", 24'h1C, {16'h0, flash_status});
	endtask
	task automatic t_prog();
		wr_idx = 8'h00;
		sfcs_flash_model_inst.pq.delete();
		run(4'h2, 24'h000100, 16'h0003, 8'h0);
		chk_log('{8'h06, 8'h02});
		cmp("program address", 24'h000100, sfcs_flash_model_inst.adr);
		cmp("program count", 24'h3, 24'(sfcs_flash_model_inst.pq.size()));
		foreach (sfcs_flash_model_inst.pq[i])
			cmp("program byte", 24'(8'h50 + i), {16'h0, sfcs_flash_model_inst.pq[i]});
		run(4'h2, 24'h000200, 16'h0000, 8'h0);
		chk_log('{8'h06, 8'h02});
	endtask
	task automatic t_erase();
		run(4'h3, 24'h012FFF, 16'h0, 8'h0);
		chk_log('{8'h06, 8'h20, 8'h05, 8'h05, 8'h05});
		cmp("erase address", 24'h012FFF, sfcs_flash_model_inst.adr);
		cmp("sector", 24'h000012, {12'h0, sfcs_flash_model_inst.sect});
		cmp("busy bit", 24'h0, {23'h0, flash_status[0]});
	endtask
	task automatic t_read();
		rdq.delete();
		rd_ready = 1'b0;
		issue(4'h0, 24'h000040, 16'h0004, 8'h0);
		// receiver stalls long enough for the buffer to fill and refuse
		repeat (700) @(posedge clk_sys);
		#1;
		cmp("stalled valid", 24'h1, {23'h0, rd_valid});
		cmp("stalled select", 24'h0, {23'h0, flash_cs_n});
		rd_ready = 1'b1;
		finish_op();
		chk_log('{8'h03});
		chk_rd(8'h40, 4);
		rdq.delete();
		run(4'h1, 24'h000080, 16'h0003, 8'h0);
		chk_log('{8'h6B});
		chk_rd(8'h80, 3);
	endtask
	initial begin
		#1000000;
		bad_count++;
		$display("MISMATCH watchdog expected finish seen hang");
		conclude();
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		#1;
		reset = 1'b0;
		@(posedge clk_sys);
		#1;
		cmp("reset select", 24'h1, {23'h0, flash_cs_n});
		cmp("reset state", 24'h0, {22'h0, op_in_progress_state});
		t_ident();
		t_regs();
		t_prog();
		t_erase();
		t_read();
		conclude();
	end
endmodule // sfcs_seq_tb
